// ### iss_pkg.sv
// package: register map, instruction fields and state types of the instruction subset executor
package iss_pkg;
   // register byte offsets on the avalon slave
   localparam logic [9:0] OFS_INSTRUCTION       = 10'h000;
   localparam logic [9:0] OFS_ACCUMULATOR       = 10'h004;
   localparam logic [9:0] OFS_HIGH_PAGE_BUFFER  = 10'h008;
   localparam logic [9:0] OFS_TABLE_HIGH_PTR    = 10'h00C;
   localparam logic [9:0] OFS_PROGRAM_COUNTER   = 10'h010;
   localparam logic [9:0] OFS_STATUS            = 10'h014;
   localparam logic [9:0] OFS_STACK_POINTER     = 10'h018;
   localparam logic [9:0] OFS_FILE_BASE         = 10'h100;
   localparam logic [9:0] OFS_STACK_BASE        = 10'h200;

   // instruction word fields
   localparam int IMM_LSB   = 0;
   localparam int FADDR_LSB = 8;
   localparam int BIT_LSB   = 14;
   localparam int OP_LSB    = 17;
   localparam int INSTR_W   = 20;

   // status register fields
   localparam int ST_ZERO   = 0;
   localparam int ST_BUSY   = 1;
   localparam int ST_SKIP   = 2;
   localparam int ST_SP_LSB = 4;

   // sizes and reset values
   localparam int FILE_DEPTH  = 64;
   localparam int STACK_DEPTH = 8;
   localparam int PC_W        = 10;
   localparam int SP_W        = 3;
   localparam logic [7:0]      RST_ACC = 8'h00;
   localparam logic [PC_W-1:0] RST_PC  = 10'h000;
   localparam logic [SP_W-1:0] RST_SP  = 3'h0;
   localparam logic [PC_W-1:0] PC_STEP = 10'h001;

   // operation codes of the instruction word
   typedef enum logic [2:0] {
      OP_AND_IMMEDIATE_INTO_ACCUMULATOR = 3'h0,
      OP_BIT_SET_IN_FILE_REGISTER       = 3'h1,
      OP_TEST_BIT_SKIP_WHEN_CLEAR       = 3'h2,
      OP_TEST_BIT_SKIP_WHEN_SET         = 3'h3,
      OP_SUBROUTINE_JUMP_IMMEDIATE      = 3'h4,
      OP_SUBROUTINE_JUMP_COMPUTED       = 3'h5
   } opcode_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXECUTE,
      ST_SECOND
   } exec_state_t;

   // whole state of the executor
   typedef struct packed {
      exec_state_t                      state;
      logic [INSTR_W-1:0]               instr;
      logic [7:0]                       accumulator;
      logic [7:0]                       high_page_buffer;
      logic [7:0]                       table_high_pointer;
      logic [PC_W-1:0]                  pc;
      logic [PC_W-1:0]                  target;
      logic                             call_pending;
      logic                             zero;
      logic                             skip_taken;
      logic [SP_W-1:0]                  sp;
      logic [FILE_DEPTH-1:0][7:0]       file_reg;
      logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
      logic                             rd_done;
      logic [31:0]                      readdata;
   } core_state_t;
endpackage

// ### instruction_subset_exec.sv
// instruction subset executor: six core instructions behind an avalon-mm slave
// Behaviour
// - immediate and into accumulator, zero flag, one cycle
// - bit set forces file bit, zero flag kept
// - skip next when tested bit is zero
// - skip next when tested bit is one
// - taken skip runs nop, two cycles total
// - calls push pc plus one on stack
// - immediate call: high page buffer, operand
// - computed call: table pointer, accumulator
`timescale 1ns/100ps
`default_nettype none
module instruction_subset_exec (
   input  wire logic        clk_sys_i,
   input  wire logic        sys_rst_i,
   input  wire logic [9:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   output logic             busy_o
);

   iss_pkg::core_state_t s;
   iss_pkg::core_state_t next_s;

   // merge the enabled byte lanes of a write into the old word
   function automatic logic [31:0] merge_lanes(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  be);
      logic [31:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // decoded fields of the held instruction
   logic [7:0]              imm;
   logic [5:0]              faddr;
   logic [2:0]              bitsel;
   iss_pkg::opcode_t        op;
   logic [7:0]              file_val;
   logic                    tested_bit;
   logic [iss_pkg::PC_W-1:0] pc_next_seq;
   logic                    busy;
   logic                    bus_stall;
   logic                    wr_ok;
   logic [7:0]              waddr;
   logic [31:0]             status_word;

   assign imm         = s.instr[iss_pkg::IMM_LSB +: 8];
   assign faddr       = s.instr[iss_pkg::FADDR_LSB +: 6];
   assign bitsel      = s.instr[iss_pkg::BIT_LSB +: 3];
   assign op          = iss_pkg::opcode_t'(s.instr[iss_pkg::OP_LSB +: 3]);
   assign file_val    = s.file_reg[faddr];
   assign tested_bit  = file_val[bitsel];
   assign pc_next_seq = s.pc + iss_pkg::PC_STEP;
   assign busy        = (s.state != iss_pkg::ST_IDLE);
   assign waddr       = avs_address_i[9:2];
   assign status_word = {25'h0000000, s.sp, 1'b0, s.skip_taken, busy, s.zero};

   // writes wait while an instruction runs so software never races the core
   assign bus_stall = avs_write_i & busy;
   assign wr_ok     = avs_write_i & ~busy;

   assign avs_waitrequest_o = (avs_read_i & ~s.rd_done) | bus_stall;
   assign avs_readdata_o    = s.readdata;
   assign busy_o            = busy;

   // next state: bus access, then the execution sequencer
   always_comb begin
      logic [31:0] rd;
      logic [31:0] wv;
      rd     = 32'h00000000;
      wv     = 32'h00000000;
      next_s = s;

      // register read, answered one cycle later from a flop
      next_s.rd_done = avs_read_i & ~s.rd_done;
      if (avs_read_i & ~s.rd_done) begin
         if (avs_address_i[9:8] == iss_pkg::OFS_FILE_BASE[9:8]) begin
            rd = {24'h000000, s.file_reg[avs_address_i[7:2]]};
         end else if (avs_address_i[9:8] == iss_pkg::OFS_STACK_BASE[9:8]) begin
            if (avs_address_i[7:5] == 3'h0) begin
               rd = {22'h000000, s.stack[avs_address_i[4:2]]};
            end
         end else begin
            unique case ({avs_address_i[9:2], 2'b00})
               iss_pkg::OFS_INSTRUCTION:      rd = {12'h000, s.instr};
               iss_pkg::OFS_ACCUMULATOR:      rd = {24'h000000, s.accumulator};
               iss_pkg::OFS_HIGH_PAGE_BUFFER: rd = {24'h000000, s.high_page_buffer};
               iss_pkg::OFS_TABLE_HIGH_PTR:   rd = {24'h000000, s.table_high_pointer};
               iss_pkg::OFS_PROGRAM_COUNTER:  rd = {22'h000000, s.pc};
               iss_pkg::OFS_STATUS:           rd = status_word;
               iss_pkg::OFS_STACK_POINTER:    rd = {29'h00000000, s.sp};
               default:                       rd = 32'h00000000;
            endcase
         end
         next_s.readdata = rd;
      end

      // register write; only taken while idle, unmapped writes are dropped
      if (wr_ok) begin
         if (avs_address_i[9:8] == iss_pkg::OFS_FILE_BASE[9:8]) begin
            wv = merge_lanes({24'h000000, s.file_reg[avs_address_i[7:2]]},
                             avs_writedata_i, avs_byteenable_i);
            next_s.file_reg[avs_address_i[7:2]] = wv[7:0];
         end else begin
            unique case ({waddr, 2'b00})
               iss_pkg::OFS_INSTRUCTION: begin
                  wv = merge_lanes({12'h000, s.instr}, avs_writedata_i, avs_byteenable_i);
                  next_s.instr = wv[iss_pkg::INSTR_W-1:0];
                  next_s.state = iss_pkg::ST_EXECUTE; // writing the word launches it
               end
               iss_pkg::OFS_ACCUMULATOR: begin
                  wv = merge_lanes({24'h000000, s.accumulator}, avs_writedata_i,
                                   avs_byteenable_i);
                  next_s.accumulator = wv[7:0];
               end
               iss_pkg::OFS_HIGH_PAGE_BUFFER: begin
                  wv = merge_lanes({24'h000000, s.high_page_buffer}, avs_writedata_i,
                                   avs_byteenable_i);
                  next_s.high_page_buffer = wv[7:0];
               end
               iss_pkg::OFS_TABLE_HIGH_PTR: begin
                  wv = merge_lanes({24'h000000, s.table_high_pointer}, avs_writedata_i,
                                   avs_byteenable_i);
                  next_s.table_high_pointer = wv[7:0];
               end
               iss_pkg::OFS_PROGRAM_COUNTER: begin
                  wv = merge_lanes({22'h000000, s.pc}, avs_writedata_i, avs_byteenable_i);
                  next_s.pc = wv[iss_pkg::PC_W-1:0];
               end
               iss_pkg::OFS_STATUS: begin
                  wv = merge_lanes(status_word, avs_writedata_i, avs_byteenable_i);
                  next_s.zero = wv[iss_pkg::ST_ZERO];
               end
               iss_pkg::OFS_STACK_POINTER: begin
                  wv = merge_lanes({29'h00000000, s.sp}, avs_writedata_i, avs_byteenable_i);
                  next_s.sp = wv[iss_pkg::SP_W-1:0];
               end
               default: begin
                  wv = 32'h00000000;
               end
            endcase
         end
      end

      // execution sequencer
      unique case (s.state)
         iss_pkg::ST_IDLE: begin
         end
         iss_pkg::ST_EXECUTE: begin
            next_s.skip_taken   = 1'b0;
            next_s.call_pending = 1'b0;
            next_s.state        = iss_pkg::ST_IDLE;
            next_s.pc           = pc_next_seq;
            unique case (op)
               iss_pkg::OP_AND_IMMEDIATE_INTO_ACCUMULATOR: begin
                  // one cycle, only the zero flag follows the result
                  next_s.accumulator = s.accumulator & imm;
                  next_s.zero = ((s.accumulator & imm) == 8'h00);
               end
               iss_pkg::OP_BIT_SET_IN_FILE_REGISTER: begin
                  next_s.file_reg[faddr][bitsel] = 1'b1;
               end
               iss_pkg::OP_TEST_BIT_SKIP_WHEN_CLEAR: begin
                  if (!tested_bit) begin
                     next_s.skip_taken = 1'b1;
                     next_s.state      = iss_pkg::ST_SECOND;
                  end
               end
               iss_pkg::OP_TEST_BIT_SKIP_WHEN_SET: begin
                  if (tested_bit) begin
                     next_s.skip_taken = 1'b1;
                     next_s.state      = iss_pkg::ST_SECOND;
                  end
               end
               iss_pkg::OP_SUBROUTINE_JUMP_IMMEDIATE: begin
                  next_s.stack[s.sp]  = pc_next_seq;
                  next_s.sp           = s.sp + 3'h1;
                  next_s.target       = {s.high_page_buffer[1:0], imm};
                  next_s.call_pending = 1'b1;
                  next_s.state        = iss_pkg::ST_SECOND;
               end
               iss_pkg::OP_SUBROUTINE_JUMP_COMPUTED: begin
                  next_s.stack[s.sp]  = pc_next_seq;
                  next_s.sp           = s.sp + 3'h1;
                  next_s.target       = {s.table_high_pointer[1:0], s.accumulator};
                  next_s.call_pending = 1'b1;
                  next_s.state        = iss_pkg::ST_SECOND;
               end
               default: begin
                  // unused codes retire as a plain no-operation
               end
            endcase
         end
         iss_pkg::ST_SECOND: begin
            // the prefetched word is dropped: a call jumps, a skip steps past it
            if (s.call_pending) begin
               next_s.pc = s.target;
            end else begin
               next_s.pc = pc_next_seq;
            end
            next_s.call_pending = 1'b0;
            next_s.state        = iss_pkg::ST_IDLE;
         end
      endcase
   end

   // single register stage for the whole state
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         s             <= '0;
         s.state       <= iss_pkg::ST_IDLE;
         s.accumulator <= iss_pkg::RST_ACC;
         s.pc          <= iss_pkg::RST_PC;
         s.sp          <= iss_pkg::RST_SP;
      end else begin
         s <= next_s;
      end
   end

endmodule // instruction_subset_exec
`default_nettype wire

// ### instruction_subset_exec_sva.sv
// checker: port-level timing of the instruction subset executor
`timescale 1ns/100ps
`default_nettype none
module instruction_subset_exec_sva (
   input wire logic        clk_sys_i,
   input wire logic        sys_rst_i,
   input wire logic [9:0]  avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0]  avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o,
   input wire logic        busy_o
);
   logic       launch;
   logic [2:0] op;
   // a full-word instruction write that meets an idle core starts execution
   assign launch = avs_write_i && !avs_waitrequest_o && avs_address_i[9:2] == 8'h00
                   && avs_byteenable_i == 4'hF;
   assign op = avs_writedata_i[19:17];
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   AST_ONE_CYCLE: assert property (launch && !(op inside {[3'h2:3'h5]}) |=> busy_o ##1 !busy_o)
      else $error("single-cycle instruction length wrong");
   AST_TEST_LEN: assert property (launch && op inside {3'h2, 3'h3} |=> busy_o ##2 !busy_o)
      else $error("bit test exceeded two cycles");
   AST_CALL_LEN: assert property (launch && op inside {3'h4, 3'h5} |=> busy_o [*2] ##1 !busy_o)
      else $error("call did not take two cycles");
   AST_BUSY_CAUSE: assert property ($rose(busy_o) |-> $past(launch))
      else $error("busy rose without an instruction");
   AST_WR_STALL: assert property (avs_write_i && busy_o |-> avs_waitrequest_o)
      else $error("write accepted while busy");
   AST_WR_FREE: assert property (avs_write_i && !busy_o |-> !avs_waitrequest_o)
      else $error("idle write stalled");
   AST_RD_WAIT: assert property ($rose(avs_read_i) |-> avs_waitrequest_o)
      else $error("read answered without its wait cycle");
   AST_RD_DONE: assert property (avs_read_i && avs_waitrequest_o ##1 avs_read_i |-> !avs_waitrequest_o)
      else $error("read took more than one wait cycle");
   AST_UNMAPPED: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[9:8] == 2'h3
                                  |-> avs_readdata_o == 32'h0)
      else $error("unmapped read not zero");
endmodule // instruction_subset_exec_sva
bind instruction_subset_exec instruction_subset_exec_sva i_sva (.clk_sys_i(clk_sys_i),
   .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .busy_o(busy_o));
`default_nettype wire

// ### instruction_subset_exec_test.sv
// testbench: model-checked random run of the instruction subset executor
`timescale 1ns/100ps
`default_nettype none
module instruction_subset_exec_test;
   logic        clk_sys_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic [9:0]  avs_address_i = 10'h000;
   logic        avs_read_i = 1'b0;
   logic        avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0]  avs_byteenable_i = 4'hF;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic        busy_o;
   logic [31:0] rdv;
   int miscompares = 0;
   int compares = 0;
   int accu, hpb, thp, pc, zf, skp, sp, fa;
   int fr[64];
   int stk[8];
   always #5 clk_sys_i = ~clk_sys_i;
   instruction_subset_exec i_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .busy_o(busy_o));
   task automatic end_of_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // one bus cycle; held until waitrequest is seen low, then one idle cycle
   // waitrequest is looked at mid-cycle, where it is settled, so the edge sample never races
   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
      int n;
      logic done;
      n = 0;
      done = 1'b0;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= !w;
      while (!done && n < 40) begin
         @(negedge clk_sys_i);
         done = (avs_waitrequest_o === 1'b0);
         if (done) rdv = avs_readdata_o;
         @(posedge clk_sys_i);
         n++;
      end
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge clk_sys_i);
      if (!done) begin
         miscompares++;
         $display("[ERR] waitrequest expected 0 seen 1");
         end_of_test();
      end
   endtask
   // waits for idle first, since registers mid-instruction are not final
   task automatic chk(input string nm, input logic [9:0] a, input int e);
      int n;
      logic idle;
      n = 0;
      idle = 1'b0;
      while (!idle && n < 20) begin
         @(negedge clk_sys_i);
         idle = (busy_o === 1'b0);
         @(posedge clk_sys_i);
         n++;
      end
      if (!idle) begin
         miscompares++;
         $display("[ERR] busy before %0s expected 0 seen 1", nm);
         end_of_test();
      end
      bus(1'b0, a, 32'h0);
      compares++;
      if (rdv !== 32'(e)) begin
         miscompares++;
         $display("[ERR] %0s expected %0h seen %0h", nm, e, rdv);
      end
   endtask
   // launch one instruction and step the reference model
   task automatic run(input int o, input int b, input int i);
      bus(1'b1, iss_pkg::OFS_INSTRUCTION, 32'((o << 17) | (b << 14) | (fa << 8) | i));
      pc = (pc + 1) % 1024;
      skp = (o == 2 || o == 3) && (((fr[fa] >> b) & 1) == o - 2);
      pc = (pc + skp) % 1024;
      if (o == 0) begin
         accu = accu & i;
         zf = (accu == 0);
      end
      if (o == 1) fr[fa] = fr[fa] | (1 << b);
      if (o == 4 || o == 5) begin
         stk[sp] = pc;
         sp = (sp + 1) % 8;
         pc = ((o == 4 ? hpb : thp) % 4) * 256 + (o == 4 ? i : accu);
      end
   endtask
   initial begin
      void'($urandom(8473));
      {accu, hpb, thp, pc, zf, skp, sp} = '0;
      foreach (fr[j]) fr[j] = 0;
      foreach (stk[j]) stk[j] = 0;
      repeat (3) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_sys_i);
      chk("accumulator", iss_pkg::OFS_ACCUMULATOR, 0);
      chk("status", iss_pkg::OFS_STATUS, 0);
      chk("pc", iss_pkg::OFS_PROGRAM_COUNTER, 0);
      $display("test reset done");
      // instructions go in pairs: operands are loaded before the first, results are checked after the second
      for (int k = 0; k < 64; k++) begin
         if (k % 2 == 0) begin
            accu = $urandom % 256;
            hpb = $urandom % 256;
            thp = $urandom % 256;
            bus(1'b1, iss_pkg::OFS_ACCUMULATOR, 32'(accu));
            bus(1'b1, iss_pkg::OFS_HIGH_PAGE_BUFFER, 32'(hpb));
            bus(1'b1, iss_pkg::OFS_TABLE_HIGH_PTR, 32'(thp));
         end
         fa = $urandom % 64;
         fr[fa] = $urandom % 256;
         bus(1'b1, iss_pkg::OFS_FILE_BASE + 10'(4 * fa), 32'(fr[fa]));
         run(k % 8, $urandom % 8, (k < 8) ? 0 : $urandom % 256);
         if (k % 2 == 1) begin
            chk("accumulator", iss_pkg::OFS_ACCUMULATOR, accu);
            chk("pc", iss_pkg::OFS_PROGRAM_COUNTER, pc);
            chk("status", iss_pkg::OFS_STATUS, zf + skp * 4 + sp * 16);
            chk("file", iss_pkg::OFS_FILE_BASE + 10'(4 * fa), fr[fa]);
            chk("stack", iss_pkg::OFS_STACK_BASE + 10'(4 * ((sp + 7) % 8)), stk[(sp + 7) % 8]);
         end
      end
      $display("test random done");
      // a disabled lane keeps its byte, an enabled one takes the new value
      avs_byteenable_i <= 4'hE;
      bus(1'b1, iss_pkg::OFS_ACCUMULATOR, 32'hFFFFFF00 | $urandom);
      chk("accumulator lane off", iss_pkg::OFS_ACCUMULATOR, accu);
      avs_byteenable_i <= 4'h1;
      accu = $urandom % 256;
      bus(1'b1, iss_pkg::OFS_ACCUMULATOR, 32'hFFFFFF00 | 32'(accu));
      avs_byteenable_i <= 4'hF;
      chk("accumulator lane on", iss_pkg::OFS_ACCUMULATOR, accu);
      // software may set the zero flag; stack pointer reads back as the model has it
      bus(1'b1, iss_pkg::OFS_STATUS, 32'h00000001);
      zf = 1;
      chk("status zero write", iss_pkg::OFS_STATUS, zf + skp * 4 + sp * 16);
      chk("stack pointer", iss_pkg::OFS_STACK_POINTER, sp);
      $display("test lanes done");
      bus(1'b1, 10'h300, 32'hFFFFFFFF);
      chk("unmapped", 10'h300, 0);
      chk("accumulator", iss_pkg::OFS_ACCUMULATOR, accu);
      $display("test unmapped done");
      end_of_test();
   end
endmodule // instruction_subset_exec_test
`default_nettype wire
